// >>> dpeq_aux_snoop.sv
module dpeq_aux_snoop
  import dpeq_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic aux_sot,
  input wire logic aux_byte_valid,
  input wire logic [7:0] aux_byte,
  input wire logic aux_eot,
  output logic pwr_hit,
  output logic lcnt_hit,
  output logic [7:0] snoop_data
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR_MID, ST_ADDR_LO, ST_LEN, ST_DATA, ST_HAVE, ST_SKIP
  } dpeq_snoop_state_type;

  typedef struct packed {
    dpeq_snoop_state_type st;
    logic [19:0] addr;
    logic [7:0] data;
    logic pwr_hit;
    logic lcnt_hit;
  } dpeq_snoop_type;

  dpeq_snoop_type r_ff;
  dpeq_snoop_type nxt_r;

  always_comb begin
    nxt_r = r_ff;
    nxt_r.pwr_hit = 1'b0;
    nxt_r.lcnt_hit = 1'b0;
    // A new start abandons any request still open, so a cut-off write never lands.
    if (aux_sot) begin
      nxt_r.st = ST_IDLE;
    end else if (aux_eot) begin
      if (r_ff.st == ST_HAVE) begin
        nxt_r.pwr_hit = (r_ff.addr == DPEQ_DPCD_PWR);
        nxt_r.lcnt_hit = (r_ff.addr == DPEQ_DPCD_LCNT);
      end
      nxt_r.st = ST_SKIP;
    end else if (aux_byte_valid) begin
      case (r_ff.st)
        ST_IDLE: begin
          nxt_r.addr[19:16] = aux_byte[3:0];
          nxt_r.st = (aux_byte[7:4] == DPEQ_AUX_NATIVE_WR) ? ST_ADDR_MID : ST_SKIP;
        end
        ST_ADDR_MID: begin
          nxt_r.addr[15:8] = aux_byte;
          nxt_r.st = ST_ADDR_LO;
        end
        ST_ADDR_LO: begin
          nxt_r.addr[7:0] = aux_byte;
          nxt_r.st = ST_LEN;
        end
        ST_LEN: begin
          nxt_r.st = ST_DATA;
        end
        ST_DATA: begin
          nxt_r.data = aux_byte;
          nxt_r.st = ST_HAVE;
        end
        default: begin
          nxt_r.st = r_ff.st;
        end
      endcase
    end
    if (!rstn) begin
      nxt_r = '{st: ST_SKIP, addr: 20'h00000, data: 8'h00, pwr_hit: 1'b0, lcnt_hit: 1'b0};
    end
  end

  always_ff @(posedge clk) begin
    r_ff <= nxt_r;
  end

  assign pwr_hit = r_ff.pwr_hit;
  assign lcnt_hit = r_ff.lcnt_hit;
  assign snoop_data = r_ff.data;
endmodule // dpeq_aux_snoop

// >>> dpeq_aux_src.sv
module dpeq_aux_src (
  input wire logic clk,
  output logic aux_sot,
  output logic aux_byte_valid,
  output logic [7:0] aux_byte,
  output logic aux_eot
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    aux_sot = 1'b0;
    aux_byte_valid = 1'b0;
    aux_byte = 8'h00;
    aux_eot = 1'b0;
  end
  // A cut request ends in a fresh start pulse, never in an end pulse.
  task automatic send(input logic [3:0] cmd, input logic [19:0] adr, input logic [7:0] dat,
                      input bit cut);
    logic [7:0] b [5];
    b = '{{cmd, adr[19:16]}, adr[15:8], adr[7:0], 8'h00, dat};
    @(posedge clk);
    #1 aux_sot = 1'b1;
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      #1 aux_sot = 1'b0;
      aux_byte_valid = 1'b1;
      aux_byte = b[i];
    end
    @(posedge clk);
    #1 aux_byte_valid = 1'b0;
    // Idle bytes are inverted so a stale byte never looks valid.
    aux_byte = ~aux_byte;
    if (cut) aux_sot = 1'b1;
    else aux_eot = 1'b1;
    @(posedge clk);
    #1 aux_sot = 1'b0;
    aux_eot = 1'b0;
  endtask
endmodule // dpeq_aux_src

// >>> dpeq_pkg.sv
package dpeq_pkg;
  // Register offsets of the DisplayPort control and status bank.
  localparam logic [7:0] DPEQ_OFS_EQ13 = 8'h10;
  localparam logic [7:0] DPEQ_OFS_EQ02 = 8'h11;
  localparam logic [7:0] DPEQ_OFS_SNOOP = 8'h12;
  localparam logic [7:0] DPEQ_OFS_CTRL = 8'h13;
  // Field positions.
  localparam int DPEQ_EQ_HI_LSB = 4;
  localparam int DPEQ_EQ_LO_LSB = 0;
  localparam int DPEQ_PWR_LSB = 5;
  localparam int DPEQ_LCNT_LSB = 0;
  localparam int DPEQ_SNOOP_OFF_BIT = 7;
  localparam int DPEQ_ROUTE_LSB = 4;
  localparam int DPEQ_LANE_OFF_LSB = 0;
  // Reset values.
  localparam logic [7:0] DPEQ_RST_REG = 8'h00;
  localparam logic [3:0] DPEQ_RST_EQ = 4'h0;
  localparam logic [1:0] DPEQ_RST_PWR = 2'h0;
  localparam logic [4:0] DPEQ_RST_LCNT = 5'h00;
  localparam logic [1:0] DPEQ_RST_ROUTE = 2'h0;
  localparam logic [3:0] DPEQ_RST_LANE_OFF = 4'h0;
  // Snooped DPCD addresses and the native write request code.
  localparam logic [19:0] DPEQ_DPCD_PWR = 20'h00600;
  localparam logic [19:0] DPEQ_DPCD_LCNT = 20'h00101;
  localparam logic [3:0] DPEQ_AUX_NATIVE_WR = 4'h8;
  // Snooped power state code meaning the sink is awake.
  localparam logic [1:0] DPEQ_PWR_ACTIVE = 2'h1;
  // Sideband route codes.
  localparam logic [1:0] DPEQ_ROUTE_AUTO = 2'h0;
  localparam logic [1:0] DPEQ_ROUTE_STRAIGHT = 2'h1;
  localparam logic [1:0] DPEQ_ROUTE_SWAPPED = 2'h2;
  localparam logic [1:0] DPEQ_ROUTE_OPEN = 2'h3;
  // Mode select codes.
  localparam logic [1:0] DPEQ_MODE_OFF = 2'h0;
  localparam logic [1:0] DPEQ_MODE_USB = 2'h1;
  localparam logic [1:0] DPEQ_MODE_DP4 = 2'h2;
  localparam logic [1:0] DPEQ_MODE_DP2_USB = 2'h3;
endpackage

// >>> dpeq_regs.sv
module dpeq_regs
  import dpeq_pkg::*;
#(
  parameter int EQ_W = 4,
  parameter int LANES = 4
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_offset,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  input wire logic eq_software_select,
  input wire logic [1:0] mode_select_field,
  input wire logic orientation_select,
  input wire logic [1:0] display_eq_strap_pins,
  input wire logic aux_sot,
  input wire logic aux_byte_valid,
  input wire logic [7:0] aux_byte,
  input wire logic aux_eot,
  output logic [LANES*EQ_W-1:0] lane_eq_level,
  output logic [LANES-1:0] lane_enable,
  output logic aux_n_to_sideband_pin_one,
  output logic aux_p_to_sideband_pin_two,
  output logic aux_n_to_sideband_pin_two,
  output logic aux_p_to_sideband_pin_one
);
  import dpeq_pkg::*;

  typedef struct packed {
    logic [1:0] strap_meta;
    logic [1:0] strap_sync;
    logic mode_upper_last;
    logic [LANES-1:0][EQ_W-1:0] eq_level;
    logic [1:0] power_state;
    logic [4:0] lane_count;
    logic snoop_off;
    logic [1:0] aux_sideband_route_force;
    logic [LANES-1:0] lane_off_bits;
    logic [LANES-1:0] lane_en;
    logic [3:0] route;
    logic [7:0] rdata;
    logic hit;
  } dpeq_regs_type;

  dpeq_regs_type r_ff;
  dpeq_regs_type nxt_r;
  logic pwr_hit;
  logic lcnt_hit;
  logic [7:0] snoop_data;
  logic [LANES-1:0] snoop_lanes;
  logic [LANES-1:0] mode_lanes;

  // Two strap pins spread over the full range of the four-bit level.
  function automatic logic [EQ_W-1:0] strap_level(input logic [1:0] strap);
    strap_level = EQ_W'({strap, strap});
  endfunction

  // Lanes the mode field leaves to the display path.
  function automatic logic [LANES-1:0] lanes_of_mode(input logic [1:0] mode);
    if (mode == DPEQ_MODE_DP4) begin
      lanes_of_mode = '1;
    end else if (mode == DPEQ_MODE_DP2_USB) begin
      lanes_of_mode = LANES'(4'h3);
    end else begin
      lanes_of_mode = '0;
    end
  endfunction

  // Lanes a snooped count and power state call for.
  function automatic logic [LANES-1:0] lanes_of_snoop(input logic [1:0] pwr,
                                                      input logic [4:0] cnt);
    if (pwr != DPEQ_PWR_ACTIVE) begin
      lanes_of_snoop = '0;
    end else if (cnt == 5'h01) begin
      lanes_of_snoop = LANES'(4'h1);
    end else if (cnt == 5'h02) begin
      lanes_of_snoop = LANES'(4'h3);
    end else if (cnt == 5'h04) begin
      lanes_of_snoop = LANES'(4'hF);
    end else begin
      lanes_of_snoop = '0;
    end
  endfunction

  dpeq_aux_snoop u_snoop (
    .clk(clk),
    .rstn(rstn),
    .aux_sot(aux_sot),
    .aux_byte_valid(aux_byte_valid),
    .aux_byte(aux_byte),
    .aux_eot(aux_eot),
    .pwr_hit(pwr_hit),
    .lcnt_hit(lcnt_hit),
    .snoop_data(snoop_data)
  );

  assign snoop_lanes = lanes_of_snoop(r_ff.power_state, r_ff.lane_count);
  assign mode_lanes = lanes_of_mode(mode_select_field);

  always_comb begin
    nxt_r = r_ff;
    nxt_r.strap_meta = display_eq_strap_pins;
    nxt_r.strap_sync = r_ff.strap_meta;
    nxt_r.mode_upper_last = mode_select_field[1];
    nxt_r.hit = 1'b0;

    // Equalization levels come from the straps or from software.
    if (!eq_software_select) begin
      for (int i = 0; i < LANES; i++) begin
        nxt_r.eq_level[i] = strap_level(r_ff.strap_sync);
      end
    end else if (reg_wr && reg_offset == DPEQ_OFS_EQ13) begin
      nxt_r.eq_level[1] = reg_wdata[DPEQ_EQ_HI_LSB +: EQ_W];
      nxt_r.eq_level[3] = reg_wdata[DPEQ_EQ_LO_LSB +: EQ_W];
    end else if (reg_wr && reg_offset == DPEQ_OFS_EQ02) begin
      nxt_r.eq_level[0] = reg_wdata[DPEQ_EQ_HI_LSB +: EQ_W];
      nxt_r.eq_level[2] = reg_wdata[DPEQ_EQ_LO_LSB +: EQ_W];
    end

    // The mode clear runs first so that a snooped write in the same cycle is kept.
    if (r_ff.mode_upper_last && !mode_select_field[1]) begin
      nxt_r.power_state = DPEQ_RST_PWR;
      nxt_r.lane_count = DPEQ_RST_LCNT;
    end
    if (pwr_hit) begin
      nxt_r.power_state = snoop_data[1:0];
    end
    if (lcnt_hit) begin
      nxt_r.lane_count = snoop_data[4:0];
    end

    if (reg_wr && reg_offset == DPEQ_OFS_CTRL) begin
      nxt_r.snoop_off = reg_wdata[DPEQ_SNOOP_OFF_BIT];
      nxt_r.aux_sideband_route_force = reg_wdata[DPEQ_ROUTE_LSB +: 2];
      nxt_r.lane_off_bits = reg_wdata[DPEQ_LANE_OFF_LSB +: LANES];
    end

    if (!r_ff.snoop_off) begin
      nxt_r.lane_en = snoop_lanes & mode_lanes;
    end else begin
      nxt_r.lane_en = ~r_ff.lane_off_bits & mode_lanes;
    end

    // Route bits: n to one, p to two, n to two, p to one.
    case (r_ff.aux_sideband_route_force)
      DPEQ_ROUTE_STRAIGHT: nxt_r.route = 4'h3;
      DPEQ_ROUTE_SWAPPED: nxt_r.route = 4'hC;
      DPEQ_ROUTE_OPEN: nxt_r.route = 4'h0;
      default: begin
        if (!mode_select_field[1]) begin
          nxt_r.route = 4'h0;
        end else if (orientation_select) begin
          nxt_r.route = 4'hC;
        end else begin
          nxt_r.route = 4'h3;
        end
      end
    endcase

    if (reg_rd) begin
      nxt_r.hit = 1'b1;
      if (reg_offset == DPEQ_OFS_EQ13) begin
        nxt_r.rdata = 8'({r_ff.eq_level[1], r_ff.eq_level[3]});
      end else if (reg_offset == DPEQ_OFS_EQ02) begin
        nxt_r.rdata = 8'({r_ff.eq_level[0], r_ff.eq_level[2]});
      end else if (reg_offset == DPEQ_OFS_SNOOP) begin
        nxt_r.rdata = {1'b0, r_ff.power_state, r_ff.lane_count};
      end else if (reg_offset == DPEQ_OFS_CTRL) begin
        nxt_r.rdata = {r_ff.snoop_off, 1'b0, r_ff.aux_sideband_route_force,
                       r_ff.lane_off_bits};
      end else begin
        nxt_r.rdata = 8'h00;
        nxt_r.hit = 1'b0;
      end
    end

    if (!rstn) begin
      nxt_r.strap_meta = 2'h0;
      nxt_r.strap_sync = 2'h0;
      nxt_r.mode_upper_last = 1'b0;
      nxt_r.eq_level = '0;
      nxt_r.power_state = DPEQ_RST_PWR;
      nxt_r.lane_count = DPEQ_RST_LCNT;
      nxt_r.snoop_off = 1'b0;
      nxt_r.aux_sideband_route_force = DPEQ_RST_ROUTE;
      nxt_r.lane_off_bits = DPEQ_RST_LANE_OFF;
      nxt_r.lane_en = '0;
      nxt_r.route = 4'h0;
      nxt_r.rdata = DPEQ_RST_REG;
      nxt_r.hit = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    r_ff <= nxt_r;
  end

  assign reg_rdata = r_ff.rdata;
  assign reg_hit = r_ff.hit;
  assign lane_eq_level = r_ff.eq_level;
  assign lane_enable = r_ff.lane_en;
  assign aux_n_to_sideband_pin_one = r_ff.route[0];
  assign aux_p_to_sideband_pin_two = r_ff.route[1];
  assign aux_n_to_sideband_pin_two = r_ff.route[2];
  assign aux_p_to_sideband_pin_one = r_ff.route[3];
endmodule // dpeq_regs

// >>> dpeq_regs_asserts.sv
module dpeq_regs_asserts
  import dpeq_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_offset,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_hit,
  input wire logic eq_software_select,
  input wire logic [1:0] display_eq_strap_pins,
  input wire logic [15:0] lane_eq_level,
  input wire logic aux_n_to_sideband_pin_one,
  input wire logic aux_p_to_sideband_pin_two,
  input wire logic aux_n_to_sideband_pin_two,
  input wire logic aux_p_to_sideband_pin_one
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  logic mapped;
  logic ctl_wr;
  logic [3:0] sw;
  assign mapped = reg_offset inside {[DPEQ_OFS_EQ13:DPEQ_OFS_CTRL]};
  assign ctl_wr = reg_wr && reg_offset == DPEQ_OFS_CTRL;
  assign sw = {aux_n_to_sideband_pin_one, aux_p_to_sideband_pin_two,
               aux_n_to_sideband_pin_two, aux_p_to_sideband_pin_one};
  property p_hit;
    reg_rd && mapped |=> reg_hit;
  endproperty
  a_hit: assert property (p_hit) else $error("no hit");
  property p_unmapped;
    reg_rd && !mapped |=> !reg_hit && reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_rsv_snoop;
    reg_rd && reg_offset == DPEQ_OFS_SNOOP |=> !reg_rdata[7];
  endproperty
  a_rsv_snoop: assert property (p_rsv_snoop) else $error("bit 7 set");
  property p_rsv_ctrl;
    reg_rd && reg_offset == DPEQ_OFS_CTRL |=> !reg_rdata[6];
  endproperty
  a_rsv_ctrl: assert property (p_rsv_ctrl) else $error("bit 6 set");
  property p_straight;
    ctl_wr && reg_wdata[5:4] == DPEQ_ROUTE_STRAIGHT |-> ##[2:3] sw == 4'hC;
  endproperty
  a_straight: assert property (p_straight) else $error("route 01");
  property p_swapped;
    ctl_wr && reg_wdata[5:4] == DPEQ_ROUTE_SWAPPED |-> ##[2:3] sw == 4'h3;
  endproperty
  a_swapped: assert property (p_swapped) else $error("route 10");
  property p_open;
    ctl_wr && reg_wdata[5:4] == DPEQ_ROUTE_OPEN |-> ##[2:3] sw == 4'h0;
  endproperty
  a_open: assert property (p_open) else $error("route 11");
  property p_strap;
    (!eq_software_select && $stable(display_eq_strap_pins)) [*5]
      |-> lane_eq_level == {8{display_eq_strap_pins}};
  endproperty
  a_strap: assert property (p_strap) else $error("strap level");
  c_snoop_rd: cover property (reg_rd && reg_offset == DPEQ_OFS_SNOOP ##1 reg_hit);
  c_sw_wr: cover property (ctl_wr && eq_software_select);
  c_open: cover property (ctl_wr && reg_wdata[5:4] == DPEQ_ROUTE_OPEN);
endmodule // dpeq_regs_asserts
bind dpeq_regs dpeq_regs_asserts i_chk (.clk(clk), .rstn(rstn), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_offset(reg_offset), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_hit(reg_hit), .eq_software_select(eq_software_select),
  .display_eq_strap_pins(display_eq_strap_pins), .lane_eq_level(lane_eq_level),
  .aux_n_to_sideband_pin_one(aux_n_to_sideband_pin_one),
  .aux_p_to_sideband_pin_two(aux_p_to_sideband_pin_two),
  .aux_n_to_sideband_pin_two(aux_n_to_sideband_pin_two),
  .aux_p_to_sideband_pin_one(aux_p_to_sideband_pin_one));

// >>> tb_dp_lane_eq_and_aux_snoop_regs.sv
module tb_dp_lane_eq_and_aux_snoop_regs;
  timeunit 1ns;
  timeprecision 100ps;
  import dpeq_pkg::*;
  logic clk, rstn, reg_wr, reg_rd, sel, orient, sot, bv, eot, hit, n1, p2, n2, p1;
  logic [7:0] off, wd, rdata, ab;
  logic [1:0] mode, strap;
  logic [15:0] eq;
  logic [3:0] len;
  int miscompares = 0;
  int check_count = 0;
  int cyc = 0;
  dpeq_regs #(.EQ_W(4), .LANES(4)) i_dut (.clk(clk), .rstn(rstn), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_offset(off), .reg_wdata(wd), .reg_rdata(rdata), .reg_hit(hit),
    .eq_software_select(sel), .mode_select_field(mode), .orientation_select(orient),
    .display_eq_strap_pins(strap), .aux_sot(sot), .aux_byte_valid(bv), .aux_byte(ab),
    .aux_eot(eot), .lane_eq_level(eq), .lane_enable(len), .aux_n_to_sideband_pin_one(n1),
    .aux_p_to_sideband_pin_two(p2), .aux_n_to_sideband_pin_two(n2),
    .aux_p_to_sideband_pin_one(p1));
  dpeq_aux_src i_aux (.clk(clk), .aux_sot(sot), .aux_byte_valid(bv), .aux_byte(ab),
    .aux_eot(eot));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // The whole run needs well under a thousand cycles.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] o, input logic [7:0] d);
    @(posedge clk);
    #1 reg_wr = 1'b1;
    off = o;
    wd = d;
    @(posedge clk);
    #1 reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] o, input logic [7:0] e);
    @(posedge clk);
    #1 reg_rd = 1'b1;
    off = o;
    @(posedge clk);
    #1 reg_rd = 1'b0;
    chk({7'h00, hit, rdata}, {7'h00, o inside {[8'h10:8'h13]}, e});
  endtask
  task automatic route(input logic [1:0] c, input logic [1:0] m, input logic o,
                       input logic [3:0] e);
    mode = m;
    orient = o;
    wr(8'h13, {2'b00, c, 4'h0});
    settle(3);
    chk({12'h000, n1, p2, n2, p1}, {12'h000, e});
  endtask
  task automatic t_eq();
    sel = 1'b1;
    wr(8'h10, 8'hA5);
    wr(8'h11, 8'h3C);
    rd(8'h10, 8'hA5);
    rd(8'h11, 8'h3C);
    chk(eq, 16'h5CA3);
    sel = 1'b0;
    strap = 2'b10;
    wr(8'h10, 8'h12);
    settle(4);
    chk(eq, 16'hAAAA);
    rd(8'h10, 8'hAA);
  endtask
  task automatic t_snoop();
    mode = DPEQ_MODE_DP4;
    i_aux.send(4'h8, 20'h00600, 8'h01, 1'b0);
    i_aux.send(4'h8, 20'h00101, 8'h02, 1'b0);
    settle(4);
    rd(8'h12, 8'h22);
    chk({12'h000, len}, 16'h0003);
    wr(8'h13, 8'h0F);
    i_aux.send(4'h8, 20'h00101, 8'h04, 1'b0);
    settle(4);
    chk({12'h000, len}, 16'h000F);
    i_aux.send(4'h9, 20'h00101, 8'h01, 1'b0);
    i_aux.send(4'h8, 20'h00101, 8'h01, 1'b1);
    i_aux.send(4'h8, 20'h00602, 8'h02, 1'b0);
    settle(4);
    rd(8'h12, 8'h24);
    i_aux.send(4'h8, 20'h00600, 8'h02, 1'b0);
    settle(4);
    chk({12'h000, len}, 16'h0000);
    mode = DPEQ_MODE_OFF;
    settle(3);
    rd(8'h12, 8'h00);
  endtask
  task automatic t_ctrl();
    mode = DPEQ_MODE_DP4;
    wr(8'h13, 8'hC5);
    rd(8'h13, 8'h85);
    settle(2);
    chk({12'h000, len}, 16'h000A);
    mode = DPEQ_MODE_DP2_USB;
    settle(2);
    chk({12'h000, len}, 16'h0002);
    mode = DPEQ_MODE_USB;
    settle(2);
    chk({12'h000, len}, 16'h0000);
    route(2'h0, DPEQ_MODE_DP4, 1'b1, 4'h3);
    route(2'h0, DPEQ_MODE_DP2_USB, 1'b0, 4'hC);
    route(2'h0, DPEQ_MODE_USB, 1'b1, 4'h0);
    route(2'h1, DPEQ_MODE_DP4, 1'b1, 4'hC);
    route(2'h2, DPEQ_MODE_OFF, 1'b0, 4'h3);
    route(2'h3, DPEQ_MODE_DP4, 1'b0, 4'h0);
  endtask
  // Outputs are checked before the first edge after release, since routing moves right after.
  task automatic t_reset();
    strap = 2'b00;
    settle(4);
    rstn = 1'b0;
    settle(2);
    rstn = 1'b1;
    chk({8'h00, len, n1, p2, n2, p1}, 16'h0000);
    chk(eq, 16'h0000);
    for (int i = 0; i < 4; i++) rd(8'h10 + 8'(i), 8'h00);
  endtask
  initial begin
    rstn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    off = 8'h00;
    wd = 8'h00;
    sel = 1'b0;
    mode = 2'h0;
    orient = 1'b0;
    strap = 2'h0;
    repeat (5) @(posedge clk);
    #1 rstn = 1'b1;
    for (int i = 0; i < 5; i++) rd(8'h10 + 8'(i), 8'h00);
    t_eq();
    t_snoop();
    t_ctrl();
    t_reset();
    final_report();
  end
endmodule // tb_dp_lane_eq_and_aux_snoop_regs
